/* File: rtl/crc_regs.svh */
// Register map and field positions of the programmable CRC generator.
// Assumes a 32-bit Avalon-MM slave with byte addresses; each register uses one word.
`ifndef CRC_REGS_SVH
`define CRC_REGS_SVH

// ==========================================
// Register byte offsets
`define CRC_OFS_CONTROL_ONE 6'h00
`define CRC_OFS_CONTROL_TWO 6'h04
`define CRC_OFS_POLY_TERM_LOW 6'h08
`define CRC_OFS_POLY_TERM_HIGH 6'h0c
`define CRC_OFS_INPUT_WORD_LOW 6'h10
`define CRC_OFS_INPUT_WORD_HIGH 6'h14
`define CRC_OFS_SHIFT_VALUE_LOW 6'h18
`define CRC_OFS_SHIFT_VALUE_HIGH 6'h1c

// ==========================================
// control_one field positions
`define CRC_C1_MODULE_ON 15
`define CRC_C1_IDLE_HALT 13
`define CRC_C1_COUNT_LSB 8
`define CRC_C1_FULL 7
`define CRC_C1_EMPTY 6
`define CRC_C1_IRQ_SEL 5
`define CRC_C1_GO 4
`define CRC_C1_LSB_FIRST 3

// ==========================================
// control_two field positions
`define CRC_C2_WIDTH_LSB 8
`define CRC_C2_POLY_LEN_FIELD_LSB 0

// ==========================================
// Reset values and FIFO depths
`define CRC_RST_FIELD5 5'h00
`define CRC_RST_WORD32 32'h0000_0000
`define CRC_DEPTH_WIDE 5'h04
`define CRC_DEPTH_MID 5'h08
`define CRC_DEPTH_NARROW 5'h10
`define CRC_WIDE_ABOVE 5'h0f
`define CRC_MID_FROM 5'h08

`endif

/* File: rtl/crc_pkg.sv */
// Types used by the CRC generator; its word store keeps its own.
// Assumes the constants of crc_regs.svh for all numeric values.
`default_nettype none

package crc_pkg;
    // Engine sequencing
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_CATCH,
        ST_SHIFT,
        ST_TAIL
    } engine_state_t;

    // State of the generator, apart from the FIFO words held in crc_word_mem
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic module_on;
        logic idle_halt;
        logic irq_source_sel;
        logic shift_go;
        logic lsb_first_sel;
        logic [4:0] word_width_field;
        logic [4:0] poly_len_field;
        logic [31:1] poly_terms;
        logic [31:0] stage;
        logic [31:0] crc;
        logic [3:0] wptr;
        logic [3:0] rptr;
        logic [4:0] valid_word_count;
        engine_state_t state;
        logic [31:0] shbuf;
        logic [5:0] bits_left;
        logic [5:0] tail;
        logic irq;
    } crc_state_t;
endpackage : crc_pkg

`default_nettype wire

/* File: rtl/fifo_mem_if.sv */
// Port bundle between the CRC controller and its word store.
// Assumes one clock; read data appear one cycle after rd_en.
`default_nettype none

interface fifo_mem_if #(
    parameter int WIDTH = 32,
    parameter int AW = 4
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [WIDTH-1:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [WIDTH-1:0] rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : fifo_mem_if

`default_nettype wire

/* File: rtl/crc_word_mem.sv */
// Small word store for the CRC input FIFO, one write and one registered read port.
// Assumes the controller keeps the pointers and the fill count.
`default_nettype none

module crc_word_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Synchronous reset
    fifo_mem_if.mem port // Store access
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd_data;
    } mem_state_t;

    mem_state_t s_ff;
    mem_state_t nxt_s;

    // ==========================================
    // Elaboration check
    if (DEPTH != (1 << $clog2(DEPTH)) || WIDTH < 1) begin : g_bad
        $error("crc_word_mem: DEPTH must be a power of two");
    end

    assign port.rd_data = s_ff.rd_data;

    // Write slot, registered read
    always_comb begin
        nxt_s = s_ff;
        if (port.wr_en) begin
            nxt_s.mem[port.wr_addr] = port.wr_data;
        end
        if (port.rd_en) begin
            nxt_s.rd_data = s_ff.mem[port.rd_addr];
        end
    end

    // Contents need no reset, only the read register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_ff.rd_data <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule : crc_word_mem

`default_nettype wire

/* File: rtl/programmable_crc_generator.sv */
// Programmable CRC generator up to 32 bits with an input FIFO and a two-bit-per-cycle engine.
// Assumes an Avalon-MM master on ref_clk and an idle_mode level from logic on the same clock.
//
// Contract
// - Polynomials up to order 32; length field sets highest exponent.
// - Each set term bit XORs feedback into that engine position; clear disables.
// - Constant term always XORed; term bit 0 ignored; x32 implied for length 32.
// - Word width 1 to 32 bits; field holds width minus one.
// - FIFO depth 4 above 15, 8 for 8..15, 16 below 8.
// - Smallest FIFO write is one byte; bits above width ignored.
// - Count rises only when the byte with the word's MSb is written.
// - Engine shifts only with start bit set and count above zero.
// - Word moves to buffer, count drops, then two bits per cycle.
// - Full flag at depth for width; empty flag at zero count.
// - Module off empties FIFO, resets engine, shift value and high input.
// - Direction bit 0 shifts MSb first; 1 shifts LSb first.
// - Direction only orders input bits; result stays non-reflected.
// - Select 0 fires on count 1 to 0; select 1 on hardware go clear.
// - Software clearing the start bit fires no interrupt.
// - After empty interrupt, (length field + 1)/2 cycles remain to finish.
// - On completion hardware clears start bit; result in shift value registers.
// - Idle-halt set stops the module while the device idles.
// - Input data registers read zero; writes push into FIFO.
// - Shift value writes load engine register; reads return it.
// - Length field is five bits holding length minus one.
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`include "crc_regs.svh"
`default_nettype none

module programmable_crc_generator (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [5:0] address, // Byte address
    input wire logic read, // Read request
    input wire logic write, // Write request
    input wire logic [3:0] byteenable, // Byte lanes
    input wire logic [31:0] writedata, // Write data
    output logic [31:0] readdata, // Read data
    output logic waitrequest, // Stall
    input wire logic idle_mode, // Device idle level
    output logic crc_irq // Interrupt event pulse
);
    import crc_pkg::*;

    crc_state_t s_ff;
    crc_state_t nxt_s;

    fifo_mem_if #(.WIDTH(32), .AW(4)) mem_bus ();

    crc_word_mem #(.WIDTH(32), .DEPTH(16)) u_mem (
        .ref_clk(ref_clk),
        .rst(rst),
        .port(mem_bus.mem)
    );

    // ==========================================
    // Functions

    // FIFO depth for a word width field
    function automatic logic [4:0] fifo_depth(input logic [4:0] dw);
        if (dw > `CRC_WIDE_ABOVE) begin
            fifo_depth = `CRC_DEPTH_WIDE;
        end else if (dw >= `CRC_MID_FROM) begin
            fifo_depth = `CRC_DEPTH_MID;
        end else begin
            fifo_depth = `CRC_DEPTH_NARROW;
        end
    endfunction : fifo_depth

    // Mask of the low (field + 1) bits
    function automatic logic [31:0] low_mask(input logic [4:0] f);
        low_mask = 32'hffff_ffff >> (5'h1f - f);
    endfunction : low_mask

    // One serial engine step
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b,
                                             input logic [31:1] t, input logic [4:0] pl);
        logic fb;
        fb = b ^ c[pl];
        // Bit 0 always taps; top term never stored
        crc_step = ((c << 1) ^ (fb ? {t, 1'b1} : 32'h0)) & low_mask(pl);
    endfunction : crc_step

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // ==========================================
    // Bus handshake and outputs
    logic req;
    logic wr_fire;
    logic rd_take;
    logic run;
    logic push;
    logic pop;
    logic [4:0] depth;
    logic [1:0] msb_byte;
    logic [31:0] new_stage;
    logic [31:0] loaded;
    logic [31:0] c1;
    logic [31:0] c2;
    logic [5:0] need;

    // One wait cycle per access, so the answer stands at the second edge
    assign req = read | write;
    assign waitrequest = req & ~s_ff.ack;
    assign wr_fire = write & s_ff.ack;
    assign rd_take = read & ~s_ff.ack;
    assign readdata = s_ff.rdata;
    assign crc_irq = s_ff.irq;
    assign run = ~(s_ff.idle_halt & idle_mode);
    assign depth = fifo_depth(s_ff.word_width_field);
    assign msb_byte = s_ff.word_width_field[4:3];
    assign need = ({1'b0, s_ff.poly_len_field} + 6'h01) >> 1;

    // ==========================================
    // Next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.ack = req & ~s_ff.ack;
        nxt_s.irq = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        new_stage = s_ff.stage;
        loaded = mem_bus.rd_data & low_mask(s_ff.word_width_field);
        c1 = `CRC_RST_WORD32;
        c2 = `CRC_RST_WORD32;
        mem_bus.rd_en = 1'b0;
        mem_bus.rd_addr = s_ff.rptr;

        // Read side: data sampled into a register one edge early
        if (rd_take) begin
            case (address)
                `CRC_OFS_CONTROL_ONE: begin
                    nxt_s.rdata = 32'h0;
                    nxt_s.rdata[`CRC_C1_MODULE_ON] = s_ff.module_on;
                    nxt_s.rdata[`CRC_C1_IDLE_HALT] = s_ff.idle_halt;
                    nxt_s.rdata[`CRC_C1_COUNT_LSB +: 5] = s_ff.valid_word_count;
                    nxt_s.rdata[`CRC_C1_FULL] = (s_ff.valid_word_count == depth);
                    nxt_s.rdata[`CRC_C1_EMPTY] = (s_ff.valid_word_count == 5'h00);
                    nxt_s.rdata[`CRC_C1_IRQ_SEL] = s_ff.irq_source_sel;
                    nxt_s.rdata[`CRC_C1_GO] = s_ff.shift_go;
                    nxt_s.rdata[`CRC_C1_LSB_FIRST] = s_ff.lsb_first_sel;
                end
                `CRC_OFS_CONTROL_TWO: begin
                    nxt_s.rdata = {19'h0, s_ff.word_width_field, 3'h0, s_ff.poly_len_field};
                end
                `CRC_OFS_POLY_TERM_LOW: nxt_s.rdata = {16'h0, s_ff.poly_terms[15:1], 1'b0};
                `CRC_OFS_POLY_TERM_HIGH: nxt_s.rdata = {16'h0, s_ff.poly_terms[31:16]};
                `CRC_OFS_SHIFT_VALUE_LOW: nxt_s.rdata = {16'h0, s_ff.crc[15:0]};
                `CRC_OFS_SHIFT_VALUE_HIGH: nxt_s.rdata = {16'h0, s_ff.crc[31:16]};
                default: nxt_s.rdata = 32'h0;
            endcase
        end

        // Input words: stage bytes, push when the MSb byte lands
        if (wr_fire && address == `CRC_OFS_INPUT_WORD_LOW) begin
            new_stage[15:0] = merge16(s_ff.stage[15:0], writedata[15:0], byteenable[1:0]);
            push = ~msb_byte[1] & byteenable[msb_byte[0]];
        end
        if (wr_fire && address == `CRC_OFS_INPUT_WORD_HIGH) begin
            new_stage[31:16] = merge16(s_ff.stage[31:16], writedata[15:0], byteenable[1:0]);
            push = msb_byte[1] & byteenable[msb_byte[0]];
        end
        nxt_s.stage = new_stage;
        // Full or disabled FIFO drops the word
        push = push & s_ff.module_on & (s_ff.valid_word_count < depth);
        mem_bus.wr_en = push;
        mem_bus.wr_addr = s_ff.wptr;
        mem_bus.wr_data = new_stage & low_mask(s_ff.word_width_field);
        if (push) begin
            nxt_s.wptr = s_ff.wptr + 4'h1;
        end

        // Saturating count of cycles since the FIFO ran dry
        if (run && s_ff.state != ST_IDLE && s_ff.tail != 6'h3f) begin
            nxt_s.tail = s_ff.tail + 6'h01;
        end

        // Engine
        case (s_ff.state)
            ST_IDLE: begin
                if (s_ff.shift_go && run && s_ff.valid_word_count != 5'h00) begin
                    nxt_s.state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                mem_bus.rd_en = 1'b1;
                pop = 1'b1;
                nxt_s.rptr = s_ff.rptr + 4'h1;
                nxt_s.state = ST_CATCH;
            end
            ST_CATCH: begin
                // Left-align for MSb first so bit 31 always leads
                nxt_s.shbuf = s_ff.lsb_first_sel ? loaded
                              : (loaded << (5'h1f - s_ff.word_width_field));
                nxt_s.bits_left = {1'b0, s_ff.word_width_field} + 6'h01;
                nxt_s.state = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (s_ff.shift_go && run) begin
                    // Only input order changes, feedback is the same
                    c1 = crc_step(s_ff.crc, s_ff.lsb_first_sel ? s_ff.shbuf[0] : s_ff.shbuf[31],
                                  s_ff.poly_terms, s_ff.poly_len_field);
                    c2 = crc_step(c1, s_ff.lsb_first_sel ? s_ff.shbuf[1] : s_ff.shbuf[30],
                                  s_ff.poly_terms, s_ff.poly_len_field);
                    if (s_ff.bits_left >= 6'h02) begin
                        nxt_s.crc = c2;
                        nxt_s.shbuf = s_ff.lsb_first_sel ? (s_ff.shbuf >> 2) : (s_ff.shbuf << 2);
                        nxt_s.bits_left = s_ff.bits_left - 6'h02;
                    end else begin
                        nxt_s.crc = c1;
                        nxt_s.bits_left = 6'h00;
                    end
                    if (s_ff.bits_left <= 6'h02) begin
                        nxt_s.state = (s_ff.valid_word_count != 5'h00) ? ST_FETCH : ST_TAIL;
                    end
                end
            end
            ST_TAIL: begin
                if (s_ff.shift_go && run && s_ff.valid_word_count != 5'h00) begin
                    nxt_s.state = ST_FETCH;
                end else if (run && s_ff.tail >= need) begin
                    nxt_s.state = ST_IDLE;
                    if (s_ff.shift_go) begin
                        nxt_s.shift_go = 1'b0;
                        nxt_s.irq = s_ff.irq_source_sel;
                    end
                end
            end
            default: nxt_s.state = ST_IDLE;
        endcase

        // Count follows push and pop together
        nxt_s.valid_word_count = s_ff.valid_word_count + {4'h0, push} - {4'h0, pop};
        if (pop && !push && s_ff.valid_word_count == 5'h01) begin
            nxt_s.tail = 6'h00;
            if (!s_ff.irq_source_sel) begin
                nxt_s.irq = 1'b1;
            end
        end

        // Register writes; a software go write lands after the hardware clear
        if (wr_fire) begin
            case (address)
                `CRC_OFS_CONTROL_ONE: begin
                    if (byteenable[1]) begin
                        nxt_s.module_on = writedata[`CRC_C1_MODULE_ON];
                        nxt_s.idle_halt = writedata[`CRC_C1_IDLE_HALT];
                    end
                    if (byteenable[0]) begin
                        nxt_s.irq_source_sel = writedata[`CRC_C1_IRQ_SEL];
                        nxt_s.shift_go = writedata[`CRC_C1_GO];
                        nxt_s.lsb_first_sel = writedata[`CRC_C1_LSB_FIRST];
                    end
                end
                `CRC_OFS_CONTROL_TWO: begin
                    if (byteenable[1]) begin
                        nxt_s.word_width_field = writedata[`CRC_C2_WIDTH_LSB +: 5];
                    end
                    if (byteenable[0]) begin
                        nxt_s.poly_len_field = writedata[`CRC_C2_POLY_LEN_FIELD_LSB +: 5];
                    end
                end
                `CRC_OFS_POLY_TERM_LOW: begin
                    nxt_s.poly_terms[15:1] = {byteenable[1] ? writedata[15:8] : s_ff.poly_terms[15:8],
                                              byteenable[0] ? writedata[7:1] : s_ff.poly_terms[7:1]};
                end
                `CRC_OFS_POLY_TERM_HIGH: begin
                    nxt_s.poly_terms[31:16] = merge16(s_ff.poly_terms[31:16], writedata[15:0],
                                                      byteenable[1:0]);
                end
                `CRC_OFS_SHIFT_VALUE_LOW: begin
                    nxt_s.crc[15:0] = merge16(s_ff.crc[15:0], writedata[15:0], byteenable[1:0]);
                end
                `CRC_OFS_SHIFT_VALUE_HIGH: begin
                    nxt_s.crc[31:16] = merge16(s_ff.crc[31:16], writedata[15:0], byteenable[1:0]);
                end
                default: ;
            endcase
        end

        // Module off acts as a soft reset of the datapath only
        if (!s_ff.module_on) begin
            nxt_s.valid_word_count = `CRC_RST_FIELD5;
            nxt_s.wptr = 4'h0;
            nxt_s.rptr = 4'h0;
            nxt_s.state = ST_IDLE;
            nxt_s.crc = `CRC_RST_WORD32;
            nxt_s.stage[31:16] = 16'h0;
            nxt_s.bits_left = 6'h00;
            nxt_s.tail = 6'h00;
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.state <= ST_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule : programmable_crc_generator

`default_nettype wire

/* File: tb/crc_gen_props.sv */
// Concurrent checks on the register port and interrupt of the CRC generator.
// Assumes a bind into the generator; sees only its ports.
`include "crc_regs.svh"
`default_nettype none

module crc_gen_props (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic [5:0] address, // Byte address
    input wire logic read, // Read request
    input wire logic write, // Write request
    input wire logic [31:0] readdata, // Read data
    input wire logic waitrequest, // Stall
    input wire logic crc_irq // Interrupt pulse
);
    // ==========================================
    // Shared clock, reset and read strobe
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic rd_done;
    assign rd_done = read && !waitrequest;

    property p_wait_first;
        $rose(read || write) |-> waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("new request not stalled");
    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("stall longer than one cycle");
    property p_upper_zero;
        rd_done |-> readdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_data_regs_zero;
        rd_done && (address == `CRC_OFS_INPUT_WORD_LOW || address == `CRC_OFS_INPUT_WORD_HIGH) |-> readdata == 32'h0;
    endproperty
    a_data_regs_zero: assert property (p_data_regs_zero) else $error("input register read not zero");
    property p_unmapped_zero;
        rd_done && (address > `CRC_OFS_SHIFT_VALUE_HIGH || address[1:0] != 2'b00) |-> readdata == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_empty_flag;
        rd_done && address == `CRC_OFS_CONTROL_ONE |-> readdata[6] == (readdata[12:8] == 5'h00);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("empty flag disagrees with count");
    property p_full_depth;
        rd_done && address == `CRC_OFS_CONTROL_ONE && readdata[7] |-> readdata[12:8] inside {5'h04, 5'h08, 5'h10};
    endproperty
    a_full_depth: assert property (p_full_depth) else $error("full flag at odd count");
    property p_ctrl_two_gaps;
        rd_done && address == `CRC_OFS_CONTROL_TWO |-> readdata[15:13] == 3'h0 && readdata[7:5] == 3'h0;
    endproperty
    a_ctrl_two_gaps: assert property (p_ctrl_two_gaps) else $error("field wider than five bits");
    property p_poly_bit0;
        rd_done && address == `CRC_OFS_POLY_TERM_LOW |-> readdata[0] == 1'b0;
    endproperty
    a_poly_bit0: assert property (p_poly_bit0) else $error("constant term bit readable");
    property p_irq_pulse;
        crc_irq |=> !crc_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt wider than one cycle");
    property p_reset_quiet;
        disable iff (1'b0) rst |=> !crc_irq && readdata == 32'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");

    // Main scenarios reached
    c_irq: cover property (crc_irq);
    c_full: cover property (rd_done && address == `CRC_OFS_CONTROL_ONE && readdata[7]);
    c_push_high: cover property (write && !waitrequest && address == `CRC_OFS_INPUT_WORD_HIGH);
endmodule : crc_gen_props

`default_nettype wire

/* File: tb/programmable_crc_generator_tb.sv */
// Self-checking bench for the CRC generator, driven through its Avalon-MM port.
// Assumes design files and checker compiled first.
`include "crc_regs.svh"
`default_nettype none

module programmable_crc_generator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic idle_mode = 1'b0;
    logic crc_irq;
    int mismatches = 0;
    int comparisons = 0;
    int irqs = 0;
    int n0;
    logic [31:0] q;
    logic [31:0] e;
    logic [4:0] fld [6] = '{5'h1f, 5'h10, 5'h0f, 5'h08, 5'h07, 5'h00};
    logic [4:0] dep [6] = '{5'h04, 5'h04, 5'h08, 5'h08, 5'h10, 5'h10};

    // ==========================================
    // Clock, design, interrupt tally
    always #2.5 ref_clk = ~ref_clk;
    programmable_crc_generator dut (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .idle_mode(idle_mode), .crc_irq(crc_irq));
    always @(posedge ref_clk) begin
        if (crc_irq === 1'b1) irqs++;
    end

    // ==========================================
    // Bus tasks; idle cycle between accesses avoids double drives
    task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        address <= a;
        byteenable <= be;
        writedata <= {16'h0000, d};
        write <= w;
        read <= ~w;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask : wr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 16'h0, 4'h3);
        chk(q, exp);
    endtask : rc
    // One word, low register first
    task automatic push(input logic [31:0] d, input logic [4:0] f);
        bus(1'b1, `CRC_OFS_INPUT_WORD_LOW, d[15:0], (f < 5'h08) ? 4'h1 : 4'h3);
        if (f > 5'h0f) bus(1'b1, `CRC_OFS_INPUT_WORD_HIGH, d[31:16], 4'h3);
    endtask : push
    task automatic wait_go_clear;
        do bus(1'b0, `CRC_OFS_CONTROL_ONE, 16'h0, 4'h3); while (q[4] !== 1'b0);
    endtask : wait_go_clear
    // Reference model, non-reflected
    function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d, input int w,
                                            input logic [31:0] p, input int pl, input logic lsb);
        logic fb;
        for (int i = 0; i < w; i++) begin
            fb = (lsb ? d[i] : d[w - 1 - i]) ^ c[pl];
            c = ((c << 1) ^ (fb ? (p | 32'h1) : 32'h0)) & (32'hffff_ffff >> (31 - pl));
        end
        return c;
    endfunction : crc_ref
    task automatic conclude;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // ==========================================
    // Tests
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rc(`CRC_OFS_CONTROL_ONE, 32'h0040);
        rc(`CRC_OFS_SHIFT_VALUE_LOW, 32'h0);
        rc(6'h20, 32'h0);
        wr(`CRC_OFS_CONTROL_TWO, 16'hffff);
        rc(`CRC_OFS_CONTROL_TWO, 32'h1f1f);
        wr(`CRC_OFS_POLY_TERM_LOW, 16'hffff);
        rc(`CRC_OFS_POLY_TERM_LOW, 32'hfffe);
        wr(`CRC_OFS_INPUT_WORD_LOW, 16'h1234);
        rc(`CRC_OFS_INPUT_WORD_LOW, 32'h0);
        rc(`CRC_OFS_CONTROL_ONE, 32'h0040);
        $display("test registers done");
        // Fill each width class, one refused extra
        for (int k = 0; k < 6; k++) begin
            wr(`CRC_OFS_CONTROL_ONE, 16'h8000);
            wr(`CRC_OFS_CONTROL_TWO, {3'b000, fld[k], 8'h0f});
            for (int j = 0; j < dep[k]; j++) push(32'h0000_00a5, fld[k]);
            rc(`CRC_OFS_CONTROL_ONE, {16'h0, 3'b100, dep[k], 8'h80});
            push(32'h0000_00a5, fld[k]);
            rc(`CRC_OFS_CONTROL_ONE, {16'h0, 3'b100, dep[k], 8'h80});
            wr(`CRC_OFS_CONTROL_ONE, 16'h0000);
            rc(`CRC_OFS_CONTROL_ONE, 32'h0040);
        end
        $display("test fifo depth done");
        // 16-bit polynomial, 32-bit word, msb first, completion interrupt
        wr(`CRC_OFS_CONTROL_ONE, 16'h8000);
        wr(`CRC_OFS_CONTROL_TWO, 16'h1f0f);
        wr(`CRC_OFS_POLY_TERM_LOW, 16'h1021);
        wr(`CRC_OFS_POLY_TERM_HIGH, 16'h0001);
        wr(`CRC_OFS_SHIFT_VALUE_LOW, 16'hffff);
        rc(`CRC_OFS_SHIFT_VALUE_LOW, 32'hffff);
        wr(`CRC_OFS_INPUT_WORD_LOW, 16'h3334);
        rc(`CRC_OFS_CONTROL_ONE, 32'h8040);
        wr(`CRC_OFS_INPUT_WORD_HIGH, 16'h3132);
        rc(`CRC_OFS_CONTROL_ONE, 32'h8100);
        n0 = irqs;
        wr(`CRC_OFS_CONTROL_ONE, 16'h8030);
        wait_go_clear;
        chk(32'(irqs), 32'(n0 + 1));
        e = crc_ref(32'hffff, 32'h3132_3334, 32, 32'h0001_1021, 15, 1'b0);
        rc(`CRC_OFS_SHIFT_VALUE_LOW, e);
        rc(`CRC_OFS_CONTROL_ONE, 32'h8060);
        wr(`CRC_OFS_CONTROL_ONE, 16'h0020);
        rc(`CRC_OFS_SHIFT_VALUE_LOW, 32'h0);
        rc(`CRC_OFS_CONTROL_TWO, 32'h1f0f);
        $display("test msb first done");
        // 32-bit polynomial, 6-bit words, lsb first, held by idle, empty interrupt
        wr(`CRC_OFS_CONTROL_ONE, 16'h8000);
        wr(`CRC_OFS_CONTROL_TWO, 16'h051f);
        wr(`CRC_OFS_POLY_TERM_LOW, 16'h1db7);
        wr(`CRC_OFS_POLY_TERM_HIGH, 16'h04c1);
        push(32'h0000_00ed, 5'h05);
        push(32'h0000_003a, 5'h05);
        idle_mode <= 1'b1;
        n0 = irqs;
        wr(`CRC_OFS_CONTROL_ONE, 16'ha018);
        repeat (20) @(posedge ref_clk);
        rc(`CRC_OFS_CONTROL_ONE, 32'ha218);
        idle_mode <= 1'b0;
        wait_go_clear;
        chk(32'(irqs), 32'(n0 + 1));
        e = crc_ref(crc_ref(32'h0, 32'hed, 6, 32'h04c1_1db7, 31, 1'b1), 32'h3a, 6, 32'h04c1_1db7, 31, 1'b1);
        rc(`CRC_OFS_SHIFT_VALUE_LOW, {16'h0, e[15:0]});
        rc(`CRC_OFS_SHIFT_VALUE_HIGH, {16'h0, e[31:16]});
        $display("test lsb first done");
        // Start with nothing queued, then stop by software
        wr(`CRC_OFS_SHIFT_VALUE_LOW, 16'h5a5a);
        n0 = irqs;
        wr(`CRC_OFS_CONTROL_ONE, 16'h8030);
        repeat (20) @(posedge ref_clk);
        rc(`CRC_OFS_CONTROL_ONE, 32'h8070);
        rc(`CRC_OFS_SHIFT_VALUE_LOW, 32'h5a5a);
        wr(`CRC_OFS_CONTROL_ONE, 16'h8020);
        repeat (5) @(posedge ref_clk);
        chk(32'(irqs), 32'(n0));
        $display("test stop done");
        conclude;
    end

    // Tests take a few hundred cycles
    initial begin
        #100us;
        mismatches++;
        conclude;
    end
endmodule : programmable_crc_generator_tb

bind programmable_crc_generator crc_gen_props props_i (.ref_clk(ref_clk), .rst(rst), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .crc_irq(crc_irq));

`default_nettype wire
